// ### inc/eai_pkg.sv
// Package: register map, field positions and timing of the E1 alarm interrupt block
package eai_pkg;
	// Register offsets; status is printed as 0xNB02, enable as 0xNB03 (channel digit dropped)
	localparam logic [11:0] ADDR_STATUS     = 12'hb02;
	localparam logic [11:0] ADDR_ENABLE     = 12'hb03;
	// Byte addresses on the 32-bit bus: four times the printed offset
	localparam logic [15:0] BYTE_STATUS     = 16'h2c08;
	localparam logic [15:0] BYTE_ENABLE     = 16'h2c0c;
	localparam logic [15:0] BYTE_EVENTS     = 16'h2c10;
	localparam logic [15:0] BYTE_IRQ_MASK   = 16'h2c14;
	// Status bit positions
	localparam int          ST_YEL          = 0;
	localparam int          ST_AIS          = 1;
	localparam int          ST_OOF          = 2;
	localparam int          ST_LCV          = 3;
	localparam int          ST_MYEL         = 5;
	// Enable bit positions
	localparam int          EN_YEL          = 0;
	localparam int          EN_AIS          = 1;
	localparam int          EN_OOF          = 2;
	localparam int          EN_LCV          = 3;
	localparam int          EN_RSVD4        = 4;
	localparam int          EN_MYEL         = 5;
	localparam int          EN_YEL_STATE    = 7;
	// Writable enable bits and reset values
	localparam logic [7:0]  ENABLE_WMASK    = 8'h3f;
	localparam logic [7:0]  ENABLE_RESET    = 8'h00;
	localparam logic [7:0]  STATUS_RESET    = 8'h00;
	localparam logic [7:0]  MASK_RESET      = 8'h00;
	// Consecutive non-FAS frames needed to change the yellow state
	localparam int          YEL_FRAMES      = 2;
	localparam int          YEL_DETECT_NS   = 375000;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          YEL_DETECT_CYC  = YEL_DETECT_NS / CLK_PERIOD_NS;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// Yellow detector states
	typedef enum logic [1:0] {
		EAI_YEL_IDLE  = 2'b01,
		EAI_YEL_ALARM = 2'b10
	} eai_yel_state_t;
endpackage : eai_pkg

// ### logic/eai_yellow_det.sv
// Yellow alarm detector driven by the A bit of non-FAS frames
`timescale 1ns/1ps
module eai_yellow_det #(
	parameter int FRAMES = eai_pkg::YEL_FRAMES
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// Non-FAS frame A bit strobe
	input  wire logic nfas_valid_i,
	input  wire logic a_bit_i,
	// State and change pulse
	output logic      alarm_o,
	output logic      change_o
);
	import eai_pkg::*;

	eai_yel_state_t state;
	eai_yel_state_t next_state;
	logic [3:0]     run;
	logic [3:0]     next_run;
	wire            opposite  = nfas_valid_i && (a_bit_i != (state == EAI_YEL_ALARM));
	wire            reached   = opposite && (run == 4'(FRAMES - 1));

	// Count consecutive frames that disagree with the current state
	assign next_run = !nfas_valid_i ? run : (opposite && !reached) ? run + 4'h1 : 4'h0;

	always_comb begin
		next_state = state;
		unique case (state)
			EAI_YEL_IDLE:  if (reached) next_state = EAI_YEL_ALARM;
			EAI_YEL_ALARM: if (reached) next_state = EAI_YEL_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state    <= EAI_YEL_IDLE;
			run      <= 4'h0;
			change_o <= 1'b0;
		end else begin
			state    <= next_state;
			run      <= next_run;
			change_o <= reached;
		end
	end

	assign alarm_o = (state == EAI_YEL_ALARM);
endmodule : eai_yellow_det

// ### logic/eai_alarm_irq.sv
// Receive E1 alarm and error interrupt registers with AXI4-Lite slave
// Function
// - Set yellow-change status bit 0 on each yellow alarm declare or clear.
// - Yellow-change flag holds until status read; read returns it, then clears.
// - Declare yellow alarm after A bit one in two consecutive non-FAS frames.
// - Clear yellow alarm after A bit zero in two consecutive non-FAS frames.
// - Enable bit 7 is read-only yellow alarm state; writes ignored.
// - Enable bit 5 permits CAS multiframe yellow change interrupt.
// - Enable bit 3 permits interrupt on each line code violation.
// - Enable bit 2 permits out-of-frame declare and clear interrupt.
// - Enable one permits, zero suppresses; enable bits reset to zero.
// - Enable bit 0 gates yellow change interrupt on declare and clear.
`timescale 1ns/1ps
module eai_alarm_irq #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	// Framer events
	input  wire logic              nfas_valid_i,
	input  wire logic              a_bit_i,
	input  wire logic              frame_loss_i,
	input  wire logic              ais_i,
	input  wire logic              line_code_violation_i,
	input  wire logic              cas_mf_yellow_i,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Interrupts
	output logic                   chan_irq_o,
	output logic                   irq_o,
	output logic                   yellow_alarm_state_o
);
	import eai_pkg::*;

	// Address decode used by both channels
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [15:0] w;
		w = 16'({a[ADDR_W-1:2], 2'b00});
		if (w == BYTE_STATUS)
			reg_sel = 3'h1;
		else if (w == BYTE_ENABLE)
			reg_sel = 3'h2;
		else if (w == BYTE_EVENTS)
			reg_sel = 3'h3;
		else if (w == BYTE_IRQ_MASK)
			reg_sel = 3'h4;
		else
			reg_sel = 3'h0;
	endfunction : reg_sel

	// Registers
	logic [7:0]  alarm_error_irq_status;
	logic [7:0]  alarm_error_irq_enable;
	logic [4:0]  events_status;
	logic [4:0]  events_mask;
	logic        frame_loss_q;
	logic        ais_q;
	logic        cas_mf_yellow_q;
	logic        aw_held;
	logic        w_held;
	logic [2:0]  aw_sel;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        yel_alarm;
	logic        yel_change;

	eai_yellow_det #(
		.FRAMES (YEL_FRAMES)
	) eai_yellow_det_i (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.nfas_valid_i (nfas_valid_i),
		.a_bit_i      (a_bit_i),
		.alarm_o      (yel_alarm),
		.change_o     (yel_change)
	);

	// Event detection: changes of state for the level alarms
	wire        ais_chg   = ais_i != ais_q;
	wire        oof_chg   = frame_loss_i != frame_loss_q;
	wire        myel_chg  = cas_mf_yellow_i != cas_mf_yellow_q;
	wire [7:0]  ev_vec    = {2'b00, myel_chg, 1'b0, line_code_violation_i, oof_chg, ais_chg, yel_change};

	// Bus handshakes
	wire        aw_take   = s_axi_awvalid && s_axi_awready;
	wire        w_take    = s_axi_wvalid && s_axi_wready;
	wire        ar_take   = s_axi_arvalid && s_axi_arready;
	wire        do_write  = aw_held && w_held && !s_axi_bvalid;
	wire [2:0]  ar_sel    = reg_sel(s_axi_araddr);
	wire        rd_status = ar_take && (ar_sel == 3'h1);
	wire        rd_events = ar_take && (ar_sel == 3'h3);
	wire        wr_enable = do_write && (aw_sel == 3'h2) && w_strb[0];
	wire        wr_mask   = do_write && (aw_sel == 3'h4) && w_strb[0];

	// Status: hardware set wins over read clear
	wire [7:0]  next_status = (rd_status ? STATUS_RESET : alarm_error_irq_status) | ev_vec;
	// Enable: bit 7 comes from the detector, bit 6 reserved, bit 4 stored as written
	wire [7:0]  next_enable = wr_enable ? (w_data[7:0] & ENABLE_WMASK) : alarm_error_irq_enable;

	// Second level: sticky record of raised channel interrupts
	wire        chan_event  = |(ev_vec & alarm_error_irq_enable);
	wire [4:0]  next_events = (rd_events ? 5'h00 : events_status) | {4'h0, chan_event};

	// Channel request: enabled flags only
	wire [7:0]  en_bits = {2'b00, alarm_error_irq_enable[EN_MYEL], 1'b0, alarm_error_irq_enable[EN_LCV],
	                      alarm_error_irq_enable[EN_OOF], alarm_error_irq_enable[EN_AIS],
	                      alarm_error_irq_enable[EN_YEL]};
	assign chan_irq_o = |(alarm_error_irq_status & en_bits);
	assign irq_o      = |(events_status & events_mask);
	assign yellow_alarm_state_o = yel_alarm;

	wire [7:0]  enable_view = {yel_alarm, 1'b0, alarm_error_irq_enable[5:0]};
	wire [31:0] rd_mux = (ar_sel == 3'h1) ? {24'h0, alarm_error_irq_status} :
	                     (ar_sel == 3'h2) ? {24'h0, enable_view} :
	                     (ar_sel == 3'h3) ? {27'h0, events_status} :
	                     (ar_sel == 3'h4) ? {27'h0, events_mask} : 32'h0;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			alarm_error_irq_status <= STATUS_RESET;
			alarm_error_irq_enable <= ENABLE_RESET;
			events_status          <= 5'h00;
			events_mask            <= 5'(MASK_RESET);
			frame_loss_q           <= 1'b0;
			ais_q                  <= 1'b0;
			cas_mf_yellow_q        <= 1'b0;
		end else begin
			alarm_error_irq_status <= next_status;
			alarm_error_irq_enable <= next_enable;
			events_status          <= next_events;
			events_mask            <= wr_mask ? w_data[4:0] : events_mask;
			frame_loss_q           <= frame_loss_i;
			ais_q                  <= ais_i;
			cas_mf_yellow_q        <= cas_mf_yellow_i;
		end
	end

	// Write channel: address and data captured in either order
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_sel       <= 3'h0;
			w_data       <= 32'h0;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_sel  <= reg_sel(s_axi_awaddr);
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one cycle after address, clear-on-read happens at the same edge
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (ar_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : eai_alarm_irq

// ### verification/eai_alarm_irq_chk.sv
// Checker: yellow detector and bus relations at the block ports
`timescale 1ns/1ps
module eai_alarm_irq_chk (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Watched signals
	input  wire logic        nfas_valid_i,
	input  wire logic        a_bit_i,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_bvalid,
	input  wire logic        chan_irq_o,
	input  wire logic        yellow_alarm_state_o
);
	// Last frame seen; frames need not be in adjacent cycles
	logic have;
	logic last_a;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			have   <= 1'b0;
			last_a <= 1'b0;
		end else if (nfas_valid_i) begin
			have   <= 1'b1;
			last_a <= a_bit_i;
		end
	end
	a_yel_declare: assert property (nfas_valid_i && a_bit_i && have && last_a |=> yellow_alarm_state_o)
		else $error("yellow alarm not declared");
	a_yel_clear: assert property (nfas_valid_i && !a_bit_i && have && !last_a |=> !yellow_alarm_state_o)
		else $error("yellow alarm not cleared");
	a_yel_only_frame: assert property (!$stable(yellow_alarm_state_o) |-> $past(nfas_valid_i))
		else $error("yellow state moved without a frame");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during answer");
	a_irq_drop: assert property ($fell(chan_irq_o) |-> $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
		else $error("request dropped without access");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
endmodule : eai_alarm_irq_chk

bind eai_alarm_irq eai_alarm_irq_chk eai_alarm_irq_chk_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.nfas_valid_i(nfas_valid_i), .a_bit_i(a_bit_i), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .chan_irq_o(chan_irq_o), .yellow_alarm_state_o(yellow_alarm_state_o));

// ### verification/eai_alarm_irq_tb_top.sv
// Testbench: register access, yellow alarm and event interrupts
`timescale 1ns/1ps
module eai_alarm_irq_tb_top;
	import eai_pkg::*;
	logic        ref_clk_i, reset_i, nfas_valid_i, a_bit_i, frame_loss_i, ais_i, line_code_violation_i;
	logic        cas_mf_yellow_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        chan_irq_o, irq_o, yellow_alarm_state_o;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          bad_count, n_tests;
	eai_alarm_irq eai_alarm_irq_i (.ref_clk_i, .reset_i, .nfas_valid_i, .a_bit_i, .frame_loss_i, .ais_i,
		.line_code_violation_i, .cas_mf_yellow_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_irq_o,
		.irq_o, .yellow_alarm_state_o);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chb
	// Address and data held until ready, response ready until valid, each seen at a rising edge; no wait limit, the watchdog ends a hang
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic aw_open;
		logic w_open;
		logic b_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		b_open = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b_open) begin
			@(posedge ref_clk_i);
			if (aw_open && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				w_open = 1'b0;
			end
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				rsp = s_axi_bresp;
				b_open = 1'b0;
			end
		end
		// Idle edge so the next request never re-raises a strobe in the same step
		@(posedge ref_clk_i);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		logic ar_open;
		logic r_open;
		ar_open = 1'b1;
		r_open = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (r_open) begin
			@(posedge ref_clk_i);
			if (ar_open && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				ar_open = 1'b0;
			end
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				q = s_axi_rdata;
				rsp = s_axi_rresp;
				r_open = 1'b0;
			end
		end
		@(posedge ref_clk_i);
	endtask : rd
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		chk(q, {24'h0, e});
	endtask : rdc
	task automatic frm(input logic a);
		nfas_valid_i <= 1'b1;
		a_bit_i <= a;
		@(posedge ref_clk_i) nfas_valid_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask : frm
	task automatic evt(input int b);
		if (b == ST_AIS) ais_i <= !ais_i;
		if (b == ST_OOF) frame_loss_i <= !frame_loss_i;
		if (b == ST_MYEL) cas_mf_yellow_i <= !cas_mf_yellow_i;
		line_code_violation_i <= (b == ST_LCV);
		@(posedge ref_clk_i) line_code_violation_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask : evt
	task automatic t_regs();
		rdc(BYTE_ENABLE, ENABLE_RESET);
		rdc(BYTE_STATUS, STATUS_RESET);
		wr(BYTE_ENABLE, 8'hc0);
		rdc(BYTE_ENABLE, 8'h00);
		wr(BYTE_ENABLE, 8'h2f);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
		rdc(BYTE_ENABLE, 8'h2f);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
		wr(16'h0040, 8'hff);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		rdc(BYTE_ENABLE, 8'h2f);
		rdc(16'h0040, 8'h00);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(BYTE_ENABLE, 8'h01);
		$display("test regs done");
	endtask : t_regs
	task automatic t_yellow();
		frm(1'b1);
		frm(1'b0);
		frm(1'b1);
		chb(yellow_alarm_state_o, 1'b0);
		frm(1'b1);
		chb(yellow_alarm_state_o, 1'b1);
		rdc(BYTE_ENABLE, 8'h81);
		chb(chan_irq_o, 1'b1);
		rdc(BYTE_STATUS, 8'h01);
		chb(chan_irq_o, 1'b0);
		rdc(BYTE_STATUS, 8'h00);
		frm(1'b0);
		frm(1'b0);
		chb(yellow_alarm_state_o, 1'b0);
		rdc(BYTE_STATUS, 8'h01);
		$display("test yellow done");
	endtask : t_yellow
	task automatic t_events();
		int bits[4] = '{ST_AIS, ST_OOF, ST_LCV, ST_MYEL};
		foreach (bits[k]) begin
			wr(BYTE_ENABLE, 8'h00);
			evt(bits[k]);
			chb(chan_irq_o, 1'b0);
			rdc(BYTE_STATUS, 8'h01 << bits[k]);
			wr(BYTE_ENABLE, 8'h01 << bits[k]);
			evt(bits[k]);
			chb(chan_irq_o, 1'b1);
			rdc(BYTE_STATUS, 8'h01 << bits[k]);
			chb(chan_irq_o, 1'b0);
		end
		$display("test events done");
	endtask : t_events
	task automatic t_irq();
		wr(BYTE_ENABLE, 8'h04);
		evt(ST_OOF);
		chb(irq_o, 1'b0);
		wr(BYTE_IRQ_MASK, 8'h01);
		chb(irq_o, 1'b1);
		rdc(BYTE_STATUS, 8'h04);
		rdc(BYTE_EVENTS, 8'h01);
		chb(irq_o, 1'b0);
		$display("test irq done");
	endtask : t_irq
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Whole run is well under a thousand cycles; ten thousand means a hang
	initial begin
		#1000000;
		bad_count++;
		wrap_up();
	end
	initial begin
		{nfas_valid_i, a_bit_i, frame_loss_i, ais_i, line_code_violation_i, cas_mf_yellow_i} = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, bad_count, n_tests} = '0;
		s_axi_wstrb = 4'hf;
		reset_i = 1'b1;
		repeat (5) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_yellow();
		t_events();
		t_irq();
		wrap_up();
	end
endmodule : eai_alarm_irq_tb_top
